/* File: src/cpu_register_set.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Eight-bit accumulator holds operands and results
// - Sixteen-bit index pair from high and low
// - Reset loads stack pointer with 00ff
// - Stack reload writes ff to low byte
// - Stack decrements on push, increments on pull
// - Program counter increments per fetch, jumps load
// - Reset vector fetched from fffe high, ffff low
// - Condition bits six and five read one
// - Overflow flag follows signed overflow
// - Half carry from bit three on adds
// - Mask set blocks maskable interrupts
// - Interrupt pushes, then masks, then vectors
// - Interrupt entry never pushes index high byte
// - Highest priority pending request served first
// - Interrupt return restores registers and mask
// - Reset sets mask; clear op, wait and enabled stop clear it
// - Negative flag follows result bit seven
// - Zero flag set on zero result
// - Carry from add, borrow, shifts, bit tests
// - Wait clears mask and stops core clock
// - Stop clears mask, resumes after recovery delay
// - Disabled stop causes illegal opcode reset
// - Stop enable bit permits stop when one
module cpu_register_set #(
	parameter int IRQ_LINES = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Internal memory bus
	output logic mem_req,
	output logic mem_we,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_ack,
	// Interrupt requests, bit 0 highest priority
	input wire logic [IRQ_LINES-1:0] irq_req,
	input wire logic [15:0] irq_vector,
	output logic [IRQ_LINES-1:0] irq_ack,
	// Core status
	output logic core_clk_run,
	output logic illegal_reset
);
	import cpu_regs_pkg::*;

	initial begin
		if (IRQ_LINES < 1 || IRQ_LINES > 8)
			$error("IRQ_LINES must be 1 to 8");
	end

	// ==========================================
	// Architectural registers
	logic [7:0] acc_r;
	logic [15:0] index_r;
	logic [15:0] stack_r;
	logic [15:0] pc_r;
	logic [7:0] cc_r;
	logic [31:0] cfg_r;
	logic illegal_r;
	state_t state_r;
	logic [2:0] cnt_r;
	logic [11:0] rec_r;
	logic [7:0] operand_r;
	logic int_taken_r;
	logic [7:0] pull_buf_r;
	logic op_busy;

	// ==========================================
	// AHB-Lite address phase capture
	logic wr_pend_r, rd_pend_r;
	logic [7:0] addr_r;
	logic take;
	assign take = hsel && hready && htrans[1];
	assign hreadyout = ~op_busy | ~wr_pend_r;
	assign hresp = 1'b0;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r <= ZERO_BYTE;
		end else if (clk_en && hreadyout) begin
			wr_pend_r <= take && hwrite;
			rd_pend_r <= take && !hwrite;
			addr_r <= haddr[7:0];
		end
	end

	logic wr_fire;
	assign wr_fire = clk_en && wr_pend_r && hreadyout;
	logic op_fire;
	assign op_fire = wr_fire && addr_r == OFF_OP;
	op_t op;
	assign op = op_t'(hwdata[12:8]);

	// ==========================================
	// Flag arithmetic
	function automatic logic [8:0] add9(input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
	endfunction

	function automatic logic [7:0] nz(input logic [7:0] cc,
		input logic [7:0] res);
		logic [7:0] c;
		c = cc;
		c[CC_N] = res[7];
		c[CC_Z] = res == ZERO_BYTE;
		nz = c;
	endfunction

	// ==========================================
	// Interrupt priority select
	logic [IRQ_LINES-1:0] irq_pick;
	always_comb begin
		irq_pick = '0;
		for (int i = IRQ_LINES - 1; i >= 0; i--) begin
			if (irq_req[i])
				irq_pick = IRQ_LINES'(1) << i;
		end
	end
	logic irq_go;
	assign irq_go = |irq_req && !cc_r[CC_I] && state_r == ST_RUN
		&& !wr_pend_r;

	// ==========================================
	// Stack data sequencing for interrupt entry
	logic [7:0] push_byte;
	always_comb begin
		case (cnt_r)
			3'h4: push_byte = pc_r[7:0];
			3'h3: push_byte = pc_r[15:8];
			3'h2: push_byte = index_r[7:0];
			3'h1: push_byte = acc_r;
			default: push_byte = cc_r;
		endcase
	end

	assign op_busy = state_r != ST_RUN;
	assign mem_req = state_r inside {ST_VEC_HI, ST_VEC_LO, ST_PUSH,
		ST_PULL};
	assign mem_we = state_r == ST_PUSH;
	assign mem_wdata = push_byte;
	always_comb begin
		case (state_r)
			ST_VEC_HI: mem_addr = int_taken_r ? irq_vector
				: VEC_RESET_HI;
			ST_VEC_LO: mem_addr = int_taken_r ? irq_vector + 16'h0001
				: VEC_RESET_LO;
			ST_PUSH: mem_addr = stack_r;
			ST_PULL: mem_addr = stack_r + 16'h0001;
			default: mem_addr = pc_r;
		endcase
	end

	// ==========================================
	// Sequencer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= ST_VEC_HI;
			cnt_r <= 3'h0;
			rec_r <= 12'h000;
			int_taken_r <= 1'b0;
			irq_ack <= '0;
		end else if (clk_en) begin
			irq_ack <= '0;
			case (state_r)
				ST_RUN: begin
					if (irq_go) begin
						state_r <= ST_PUSH;
						cnt_r <= INT_PUSH_COUNT;
						int_taken_r <= 1'b1;
						irq_ack <= irq_pick;
					end else if (op_fire && op == OP_INT_RET) begin
						state_r <= ST_PULL;
						cnt_r <= 3'h0;
					end else if (op_fire && op == OP_WAIT) begin
						state_r <= ST_SLEEP;
					end else if (op_fire && op == OP_STOP
						&& cfg_r[CFG_STOP_EN]) begin
						state_r <= ST_SLEEP;
						cnt_r <= 3'h7;
					end
				end
				ST_PUSH: if (mem_ack) begin
					if (cnt_r == 3'h0)
						state_r <= ST_VEC_HI;
					else
						cnt_r <= cnt_r - 3'h1;
				end
				ST_PULL: if (mem_ack) begin
					if (cnt_r == INT_PUSH_COUNT)
						state_r <= ST_RUN;
					else
						cnt_r <= cnt_r + 3'h1;
				end
				ST_VEC_HI: if (mem_ack)
					state_r <= ST_VEC_LO;
				ST_VEC_LO: if (mem_ack) begin
					state_r <= ST_RUN;
					int_taken_r <= 1'b0;
				end
				ST_SLEEP: if (|irq_req) begin
					if (cnt_r == 3'h7) begin
						state_r <= ST_RECOVER;
						rec_r <= STOP_RECOVERY;
					end else
						state_r <= ST_RUN;
					cnt_r <= 3'h0;
				end
				ST_RECOVER: begin
					if (rec_r == 12'h000)
						state_r <= ST_RUN;
					else
						rec_r <= rec_r - 12'h001;
				end
				default: state_r <= ST_RUN;
			endcase
		end
	end
	assign core_clk_run = state_r != ST_SLEEP && state_r != ST_RECOVER;

	// ==========================================
	// Program counter
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pc_r <= 16'h0000;
		end else if (clk_en) begin
			if (state_r == ST_VEC_HI && mem_ack)
				pc_r[15:8] <= mem_rdata;
			else if (state_r == ST_VEC_LO && mem_ack)
				pc_r[7:0] <= mem_rdata;
			else if (state_r == ST_PULL && mem_ack && cnt_r == 3'h3)
				pc_r[15:8] <= mem_rdata;
			else if (state_r == ST_PULL && mem_ack && cnt_r == 3'h4)
				pc_r[7:0] <= mem_rdata;
			else if (op_fire && op == OP_FETCH)
				pc_r <= pc_r + 16'h0001;
			else if (op_fire && op == OP_JUMP)
				pc_r <= hwdata[31:16];
			else if (wr_fire && addr_r == OFF_PCNT)
				pc_r <= hwdata[15:0];
		end
	end

	// ==========================================
	// Stack pointer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stack_r <= STACK_RESET;
		end else if (clk_en) begin
			if (state_r == ST_PUSH && mem_ack)
				stack_r <= stack_r - 16'h0001;
			else if (state_r == ST_PULL && mem_ack)
				stack_r <= stack_r + 16'h0001;
			else if (op_fire && (op == OP_PUSH_A || op == OP_PUSH_H))
				stack_r <= stack_r - 16'h0001;
			else if (op_fire && (op == OP_PULL_A || op == OP_PULL_H))
				stack_r <= stack_r + 16'h0001;
			else if (op_fire && op == OP_STACK_LOW_RELOAD)
				stack_r[7:0] <= STACK_LOW_RELOAD;
			else if (wr_fire && addr_r == OFF_STACK)
				stack_r <= hwdata[15:0];
		end
	end

	// ==========================================
	// Accumulator, index pair and flags
	logic [8:0] sum;
	logic [7:0] res;
	logic [7:0] cc_nxt;
	logic [7:0] acc_nxt;
	always_comb begin
		sum = 9'h000;
		res = acc_r;
		acc_nxt = acc_r;
		cc_nxt = cc_r;
		case (op)
			OP_ADD, OP_ADC: begin
				sum = add9(acc_r, operand_r, op == OP_ADC && cc_r[CC_C]);
				res = sum[7:0];
				cc_nxt = nz(cc_r, res);
				cc_nxt[CC_H] = acc_r[4] ^ operand_r[4] ^ res[4];
				cc_nxt[CC_C] = sum[8];
				cc_nxt[CC_V] = (acc_r[7] == operand_r[7])
					&& (res[7] != acc_r[7]);
				acc_nxt = res;
			end
			OP_SUB: begin
				sum = add9(acc_r, ~operand_r, 1'b1);
				res = sum[7:0];
				cc_nxt = nz(cc_r, res);
				cc_nxt[CC_C] = ~sum[8];
				cc_nxt[CC_V] = (acc_r[7] != operand_r[7])
					&& (res[7] != acc_r[7]);
				acc_nxt = res;
			end
			OP_AND, OP_ORA, OP_EOR, OP_LDA: begin
				res = op == OP_AND ? acc_r & operand_r
					: op == OP_ORA ? acc_r | operand_r
					: op == OP_EOR ? acc_r ^ operand_r : operand_r;
				cc_nxt = nz(cc_r, res);
				cc_nxt[CC_V] = 1'b0;
				acc_nxt = res;
			end
			OP_ASL, OP_ROL, OP_LSR: begin
				res = op == OP_LSR ? {1'b0, acc_r[7:1]}
					: {acc_r[6:0], op == OP_ROL && cc_r[CC_C]};
				cc_nxt = nz(cc_r, res);
				cc_nxt[CC_C] = op == OP_LSR ? acc_r[0] : acc_r[7];
				cc_nxt[CC_V] = res[7] ^ cc_nxt[CC_C];
				acc_nxt = res;
			end
			OP_BITTEST: cc_nxt[CC_C] = operand_r[hwdata[2:0]];
			default: ;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			acc_r <= ZERO_BYTE;
			index_r <= 16'h0000;
			operand_r <= ZERO_BYTE;
			pull_buf_r <= ZERO_BYTE;
		end else if (clk_en) begin
			if (state_r == ST_PULL && mem_ack && cnt_r == 3'h1)
				acc_r <= mem_rdata;
			else if (state_r == ST_PULL && mem_ack && cnt_r == 3'h2)
				index_r[7:0] <= mem_rdata;
			else if (op_fire) begin
				acc_r <= acc_nxt;
				if (op == OP_PULL_H)
					index_r[15:8] <= hwdata[23:16];
				if (op == OP_PULL_A)
					acc_r <= hwdata[23:16];
				operand_r <= hwdata[7:0];
			end else if (wr_fire && addr_r == OFF_ACC)
				acc_r <= hwdata[7:0];
			else if (wr_fire && addr_r == OFF_INDEX)
				index_r <= hwdata[15:0];
			if (op_fire && op == OP_NOP)
				operand_r <= hwdata[7:0];
			pull_buf_r <= mem_rdata;
		end
	end

	// ==========================================
	// Condition codes and interrupt mask
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cc_r <= CODES_RESET;
		end else if (clk_en) begin
			if (state_r == ST_PUSH && mem_ack && cnt_r == 3'h0)
				cc_r[CC_I] <= 1'b1;
			else if (state_r == ST_PULL && mem_ack && cnt_r == 3'h0)
				cc_r <= mem_rdata | CODES_FIXED;
			else if (op_fire && op inside {OP_MASK_CLEAR, OP_WAIT})
				cc_r[CC_I] <= 1'b0;
			else if (op_fire && op == OP_STOP && cfg_r[CFG_STOP_EN])
				cc_r[CC_I] <= 1'b0;
			else if (op_fire && op == OP_MASK_SET)
				cc_r[CC_I] <= 1'b1;
			else if (op_fire)
				cc_r <= cc_nxt | CODES_FIXED;
			else if (wr_fire && addr_r == OFF_CODES) begin
				cc_r[CC_V] <= hwdata[CC_V];
				cc_r[CC_H] <= hwdata[CC_H];
				cc_r[CC_N] <= hwdata[CC_N];
				cc_r[CC_Z] <= hwdata[CC_Z];
				cc_r[CC_C] <= hwdata[CC_C];
			end
		end
	end

	// ==========================================
	// Configuration and illegal-opcode reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg_r <= CFG_RESET;
			illegal_r <= 1'b0;
		end else if (clk_en) begin
			illegal_r <= op_fire && op == OP_STOP
				&& !cfg_r[CFG_STOP_EN];
			if (wr_fire && addr_r == OFF_CONFIG)
				cfg_r <= hwdata;
		end
	end
	assign illegal_reset = illegal_r;

	// ==========================================
	// Read data
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hrdata <= 32'h0000_0000;
		end else if (clk_en && take && !hwrite && hreadyout) begin
			case (haddr[7:0])
				OFF_ACC: hrdata <= {24'h000000, acc_r};
				OFF_INDEX: hrdata <= {16'h0000, index_r};
				OFF_STACK: hrdata <= {16'h0000, stack_r};
				OFF_PCNT: hrdata <= {16'h0000, pc_r};
				OFF_CODES: hrdata <= {24'h000000, cc_r | CODES_FIXED};
				OFF_STATUS: hrdata <= {28'h0000000, core_clk_run,
					illegal_r, state_r == ST_SLEEP && cnt_r == 3'h7,
					state_r == ST_SLEEP && cnt_r != 3'h7};
				OFF_CONFIG: hrdata <= cfg_r;
				OFF_IRQ: hrdata <= {24'h000000, pull_buf_r};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================
	// Checks
	property p_stack_reload;
		@(posedge clk) disable iff (reset)
		op_fire && op == OP_STACK_LOW_RELOAD && !op_busy
		&& state_r == ST_RUN
		&& !irq_go |=> stack_r[7:0] == STACK_LOW_RELOAD
		&& stack_r[15:8] == $past(stack_r[15:8]);
	endproperty
	a_stack_reload: assert property (p_stack_reload)
		else $error("stack low reload wrong");

	property p_fixed_bits;
		@(posedge clk) disable iff (reset)
		cc_r[6] && cc_r[5];
	endproperty
	a_fixed_bits: assert property (p_fixed_bits)
		else $error("fixed condition bits not one");

	sequence s_push_done;
		state_r == ST_PUSH && mem_ack && cnt_r == 3'h0 && clk_en;
	endsequence
	property p_mask_then_vector;
		@(posedge clk) disable iff (reset)
		s_push_done |=> cc_r[CC_I] && state_r == ST_VEC_HI;
	endproperty
	a_mask_then_vector: assert property (p_mask_then_vector)
		else $error("mask not set before vector fetch");

	property p_masked;
		@(posedge clk) disable iff (reset)
		cc_r[CC_I] |-> irq_ack == '0 || $past(!cc_r[CC_I]);
	endproperty
	a_masked: assert property (p_masked)
		else $error("interrupt taken while masked");

	property p_wait_clear;
		@(posedge clk) disable iff (reset)
		op_fire && op == OP_WAIT && state_r == ST_RUN && !irq_go
		|=> !cc_r[CC_I] && !core_clk_run;
	endproperty
	a_wait_clear: assert property (p_wait_clear)
		else $error("wait did not clear mask");

	property p_stop_illegal;
		@(posedge clk) disable iff (reset)
		clk_en && op_fire && op == OP_STOP && !cfg_r[CFG_STOP_EN]
		|=> illegal_reset && core_clk_run;
	endproperty
	a_stop_illegal: assert property (p_stop_illegal)
		else $error("disabled stop not illegal");

	property p_zero_flag;
		@(posedge clk) disable iff (reset)
		op_fire && op == OP_LDA && state_r == ST_RUN && !irq_go
		|=> cc_r[CC_Z] == (acc_r == ZERO_BYTE) && cc_r[CC_N] == acc_r[7];
	endproperty
	a_zero_flag: assert property (p_zero_flag)
		else $error("zero or negative flag wrong");

	property p_fetch_inc;
		@(posedge clk) disable iff (reset)
		op_fire && op == OP_FETCH && state_r == ST_RUN && !irq_go
		|=> pc_r == $past(pc_r) + 16'h0001;
	endproperty
	a_fetch_inc: assert property (p_fetch_inc)
		else $error("program counter did not step");
endmodule
`default_nettype wire

/* File: src/cpu_regs_pkg.sv */
package cpu_regs_pkg;
	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_ACC = 8'h00;
	localparam logic [7:0] OFF_INDEX = 8'h04;
	localparam logic [7:0] OFF_STACK = 8'h08;
	localparam logic [7:0] OFF_PCNT = 8'h0c;
	localparam logic [7:0] OFF_CODES = 8'h10;
	localparam logic [7:0] OFF_OP = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam logic [7:0] OFF_CONFIG = 8'h1c;
	localparam logic [7:0] OFF_IRQ = 8'h20;
	// ==========================================
	// Reset values and constants
	localparam logic [15:0] STACK_RESET = 16'h00ff;
	localparam logic [7:0] STACK_LOW_RELOAD = 8'hff;
	localparam logic [15:0] VEC_RESET_HI = 16'hfffe;
	localparam logic [15:0] VEC_RESET_LO = 16'hffff;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] CODES_FIXED = 8'h60;
	localparam logic [7:0] CODES_RESET = 8'h68;
	localparam logic [31:0] CFG_RESET = 32'h0000_0001;
	// ==========================================
	// Condition code bit positions
	localparam int CC_V = 7;
	localparam int CC_H = 4;
	localparam int CC_I = 3;
	localparam int CC_N = 2;
	localparam int CC_Z = 1;
	localparam int CC_C = 0;
	// Status and config bit positions
	localparam int ST_WAIT = 0;
	localparam int ST_STOP = 1;
	localparam int ST_ILLEGAL = 2;
	localparam int ST_CLKRUN = 3;
	localparam int CFG_STOP_EN = 0;
	// Stop recovery delay in core cycles
	localparam logic [11:0] STOP_RECOVERY = 12'h020;
	// ==========================================
	// Operation codes written to OFF_OP
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_ADD = 5'h01,
		OP_ADC = 5'h02,
		OP_SUB = 5'h03,
		OP_AND = 5'h04,
		OP_ORA = 5'h05,
		OP_EOR = 5'h06,
		OP_LDA = 5'h07,
		OP_ASL = 5'h08,
		OP_LSR = 5'h09,
		OP_ROL = 5'h0a,
		OP_PUSH_A = 5'h0b,
		OP_PULL_A = 5'h0c,
		OP_PUSH_H = 5'h0d,
		OP_PULL_H = 5'h0e,
		OP_STACK_LOW_RELOAD = 5'h0f,
		OP_MASK_CLEAR = 5'h10,
		OP_MASK_SET = 5'h11,
		OP_FETCH = 5'h12,
		OP_JUMP = 5'h13,
		OP_INT_RET = 5'h14,
		OP_WAIT = 5'h15,
		OP_STOP = 5'h16,
		OP_BITTEST = 5'h17
	} op_t;
	// ==========================================
	// Core sequence states
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_VEC_HI = 3'b001,
		ST_VEC_LO = 3'b010,
		ST_PUSH = 3'b011,
		ST_PULL = 3'b100,
		ST_SLEEP = 3'b101,
		ST_RECOVER = 3'b110
	} state_t;
	localparam logic [2:0] INT_PUSH_COUNT = 3'h4;
endpackage

/* File: testbench/cpu_register_set_test.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_register_set_test;
	import cpu_regs_pkg::*;
	// ==========================================
	// Signals
	logic clk, reset, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, v, e, w;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic mem_req, mem_we, mem_ack, core_clk_run, illegal_reset, clk_en;
	logic [15:0] mem_addr, irq_vector;
	logic [7:0] mem_wdata, mem_rdata, cc0;
	logic [3:0] irq_req, irq_ack, slow, last_ack;
	logic [24:0] mlog [$];
	logic [24:0] ex [7];
	int n_errors, n_tests, n_ack, n_ill, n, k;
	typedef struct packed {
		op_t o;
		logic [7:0] a, m, cc, ea, ec, mk;
	} row_t;
	row_t rows [14] = '{
		'{OP_ADD, 8'h7f, 8'h01, 8'h00, 8'h80, 8'hfc, 8'hff},
		'{OP_ADD, 8'hff, 8'h01, 8'h00, 8'h00, 8'h7b, 8'hff},
		'{OP_ADC, 8'h10, 8'h20, 8'h81, 8'h31, 8'h68, 8'hff},
		'{OP_ADC, 8'h08, 8'h07, 8'h01, 8'h10, 8'h78, 8'hff},
		'{OP_SUB, 8'h80, 8'h01, 8'h10, 8'h7f, 8'hf8, 8'hff},
		'{OP_SUB, 8'h01, 8'h02, 8'h00, 8'hff, 8'h6d, 8'hff},
		'{OP_AND, 8'hf0, 8'h0f, 8'h11, 8'h00, 8'h7b, 8'hff},
		'{OP_ORA, 8'h80, 8'h01, 8'h80, 8'h81, 8'h6c, 8'hff},
		'{OP_EOR, 8'h55, 8'h55, 8'h00, 8'h00, 8'h6a, 8'hff},
		'{OP_ASL, 8'h81, 8'h81, 8'h00, 8'h02, 8'h69, 8'h7f},
		'{OP_LSR, 8'h01, 8'h01, 8'h00, 8'h00, 8'h6b, 8'h7f},
		'{OP_ROL, 8'h80, 8'h80, 8'h01, 8'h01, 8'h69, 8'h7f},
		'{OP_BITTEST, 8'h12, 8'h14, 8'h00, 8'h12, 8'h69, 8'hff},
		'{OP_LDA, 8'h12, 8'h80, 8'h03, 8'h80, 8'h6d, 8'hff}
	};
	assign hready = hreadyout;
	// ==========================================
	// Design and far side
	cpu_register_set #(.IRQ_LINES(4)) i_dut (.clk(clk), .reset(reset),
		.clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
		.irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
		.core_clk_run(core_clk_run), .illegal_reset(illegal_reset));
	mem_model i_mem (.clk(clk), .reset(reset), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .slow(slow));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (irq_ack !== 4'h0) begin
			n_ack++;
			last_ack = irq_ack;
		end
		if (illegal_reset === 1'b1) n_ill++;
		if (mem_ack === 1'b1) mlog.push_back({mem_we, mem_addr,
			mem_we ? mem_wdata : mem_rdata});
	end
	// ==========================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		v = hrdata;
	endtask
	task automatic rc(input string nm, input logic [7:0] a,
		input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(nm, v, exp);
	endtask
	task automatic op(input op_t o, input logic [15:0] hi,
		input logic [7:0] m);
		xfer(1'b1, OFF_OP, {hi, 3'b000, o, m});
	endtask
	task automatic wait_ack(input int cnt);
		while (n_ack < cnt) @(posedge clk);
		irq_req <= 4'h0;
		xfer(1'b1, 8'h3c, 32'h0);
	endtask
	task automatic do_reset;
		reset <= 1'b1;
		repeat (20) @(posedge clk);
		mlog.delete();
		reset <= 1'b0;
		@(posedge clk);
		xfer(1'b1, 8'h3c, 32'h0);
	endtask
	task automatic results;
		$display("Comparisons %0d, errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#300000;
		n_errors++;
		results;
	end
	// ==========================================
	// Main sequence
	initial begin
		reset = 1'b1;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'b010;
		irq_req = 4'h0;
		clk_en = 1'b1;
		irq_vector = 16'h4000;
		slow = 4'h0;
		do_reset;
		chk("vec_hi", {7'h0, mlog[0]}, {8'h0, 16'hfffe, 8'hc1});
		chk("vec_lo", {7'h0, mlog[1]}, {8'h0, 16'hffff, 8'h80});
		rc("pc", OFF_PCNT, 32'hc180);
		rc("stack", OFF_STACK, {16'h0, STACK_RESET});
		rc("codes", OFF_CODES, {24'h0, CODES_RESET});
		rc("config", OFF_CONFIG, CFG_RESET);
		rc("unmapped", 8'h3c, 32'h0);
		chk("hresp", {31'h0, hresp}, 32'h0);
		foreach (rows[i]) begin
			xfer(1'b1, OFF_ACC, {24'h0, rows[i].a});
			xfer(1'b1, OFF_CODES, {24'h0, rows[i].cc});
			// The operand register is loaded one op ahead
			op(OP_NOP, 16'h0, rows[i].m);
			op(rows[i].o, 16'h0, rows[i].m);
			rc("acc", OFF_ACC, {24'h0, rows[i].ea});
			xfer(1'b0, OFF_CODES, 32'h0);
			w = {24'h0, rows[i].mk};
			e = {24'h0, rows[i].ec} & w;
			chk("flags", v & w & 32'h07, e & 32'h07);
			chk("vhi", v & w & 32'hf8, e & 32'hf8);
		end
		// Stack, index and program counter movement
		xfer(1'b1, OFF_STACK, 32'h1234);
		op(OP_STACK_LOW_RELOAD, 16'h0, 8'h00);
		rc("stack", OFF_STACK, 32'h12ff);
		op(OP_PUSH_A, 16'h0, 8'h00);
		rc("stack", OFF_STACK, 32'h12fe);
		op(OP_PULL_A, 16'h0077, 8'h00);
		rc("stack", OFF_STACK, 32'h12ff);
		rc("acc", OFF_ACC, 32'h77);
		xfer(1'b1, OFF_INDEX, 32'h003c);
		op(OP_PUSH_H, 16'h0, 8'h00);
		op(OP_PULL_H, 16'h00a5, 8'h00);
		rc("index", OFF_INDEX, 32'ha53c);
		op(OP_JUMP, 16'h1ffe, 8'h00);
		op(OP_FETCH, 16'h0, 8'h00);
		op(OP_FETCH, 16'h0, 8'h00);
		rc("pc", OFF_PCNT, 32'h2000);
		// Interrupt entry with two requests pending under the mask
		xfer(1'b1, OFF_ACC, 32'h5a);
		xfer(1'b0, OFF_CODES, 32'h0);
		cc0 = v[7:0] & 8'hf7;
		slow <= 4'h3;
		irq_req <= 4'b0110;
		repeat (20) @(posedge clk);
		chk("masked", n_ack, 0);
		mlog.delete();
		op(OP_MASK_CLEAR, 16'h0, 8'h00);
		wait_ack(1);
		chk("prio", {28'h0, last_ack}, 32'h2);
		ex = '{{1'b1, 16'h12ff, 8'h00}, {1'b1, 16'h12fe, 8'h20},
			{1'b1, 16'h12fd, 8'h3c}, {1'b1, 16'h12fc, 8'h5a},
			{1'b1, 16'h12fb, cc0}, {1'b0, 16'h4000, 8'h12},
			{1'b0, 16'h4001, 8'h34}};
		chk("count", mlog.size(), 7);
		foreach (ex[j]) chk("entry", {7'h0, mlog[j]}, {7'h0, ex[j]});
		rc("stack", OFF_STACK, 32'h12fa);
		rc("pc", OFF_PCNT, 32'h1234);
		xfer(1'b0, OFF_CODES, 32'h0);
		chk("mask", v & 32'h08, 32'h08);
		xfer(1'b1, OFF_ACC, 32'h11);
		xfer(1'b1, OFF_INDEX, 32'h0);
		op(OP_INT_RET, 16'h0, 8'h00);
		xfer(1'b1, 8'h3c, 32'h0);
		rc("pc", OFF_PCNT, 32'h2000);
		rc("acc", OFF_ACC, 32'h5a);
		rc("index", OFF_INDEX, 32'h003c);
		rc("codes", OFF_CODES, {24'h0, cc0});
		rc("stack", OFF_STACK, 32'h12ff);
		slow <= 4'h0;
		// Wait left by an interrupt
		op(OP_WAIT, 16'h0, 8'h00);
		repeat (2) @(posedge clk);
		chk("wait_clk", {31'h0, core_clk_run}, 32'h0);
		xfer(1'b0, OFF_CODES, 32'h0);
		chk("wait_mask", v & 32'h08, 32'h0);
		clk_en <= 1'b0;
		irq_req <= 4'b0001;
		repeat (4) @(posedge clk);
		chk("frozen", {31'h0, core_clk_run}, 32'h0);
		clk_en <= 1'b1;
		wait_ack(2);
		chk("wake_clk", {31'h0, core_clk_run}, 32'h1);
		// Stop left by an interrupt, then stop refused when disabled
		op(OP_STOP, 16'h0, 8'h00);
		repeat (2) @(posedge clk);
		chk("stop_clk", {31'h0, core_clk_run}, 32'h0);
		xfer(1'b0, OFF_CODES, 32'h0);
		chk("stop_mask", v & 32'h08, 32'h0);
		irq_req <= 4'b1000;
		n = 0;
		while (core_clk_run !== 1'b1) begin
			@(posedge clk);
			n++;
		end
		chk("recovery", {31'h0, n >= 32 && n <= 40}, 32'h1);
		wait_ack(3);
		xfer(1'b1, OFF_CONFIG, 32'h0);
		k = n_ill;
		op(OP_STOP, 16'h0, 8'h00);
		while (n_ill == k) @(posedge clk);
		chk("illegal", n_ill - k, 1);
		xfer(1'b1, 8'h3c, 32'h0);
		op(OP_MASK_CLEAR, 16'h0, 8'h00);
		xfer(1'b0, OFF_CODES, 32'h0);
		chk("mask_clr", v & 32'h08, 32'h0);
		op(OP_MASK_SET, 16'h0, 8'h00);
		xfer(1'b0, OFF_CODES, 32'h0);
		chk("mask_set", v & 32'h08, 32'h08);
		// Wait left by reset
		op(OP_WAIT, 16'h0, 8'h00);
		do_reset;
		rc("codes", OFF_CODES, {24'h0, CODES_RESET});
		rc("stack", OFF_STACK, {16'h0, STACK_RESET});
		results;
	end
endmodule
`default_nettype wire

/* File: testbench/mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Memory and vector store on the core's far side
module mem_model #(
	parameter logic [15:0] RST_VEC = 16'hc180,
	parameter logic [15:0] IRQ_VEC = 16'h1234,
	parameter logic [15:0] IRQ_AT = 16'h4000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Memory bus
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata,
	output logic mem_ack,
	// Extra wait cycles per access
	input wire logic [3:0] slow
);
	logic [7:0] mem [0:65535];
	logic [3:0] cnt_r;
	initial begin
		mem[16'hfffe] = RST_VEC[15:8];
		mem[16'hffff] = RST_VEC[7:0];
		mem[IRQ_AT] = IRQ_VEC[15:8];
		mem[IRQ_AT + 16'h0001] = IRQ_VEC[7:0];
	end
	// Data line toggles outside the ack cycle so stale bytes never match
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_r <= 4'h0;
			mem_ack <= 1'b0;
			mem_rdata <= 8'h5a;
		end else if (mem_req && !mem_ack && cnt_r >= slow) begin
			cnt_r <= 4'h0;
			mem_ack <= 1'b1;
			mem_rdata <= mem_we ? ~mem_rdata : mem[mem_addr];
			if (mem_we) begin
				mem[mem_addr] <= mem_wdata;
			end
		end else begin
			cnt_r <= mem_req ? cnt_r + 4'h1 : 4'h0;
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule
`default_nettype wire
